// ### design/gpp_pkg.sv
// Package with register map, field layout and types of the GPIO port block
package gpp_pkg;

    localparam int unsigned GPP_PINS = 32;
    localparam int unsigned GPP_AW   = 12;

    // ==========================================================================
    // Register offsets
    localparam logic [11:0] GPP_OFF_DRIVE_LEVEL       = 12'h004;
    localparam logic [11:0] GPP_OFF_DRIVE_LEVEL_SET   = 12'h008;
    localparam logic [11:0] GPP_OFF_DRIVE_LEVEL_CLEAR = 12'h00C;
    localparam logic [11:0] GPP_OFF_INPUT_LEVEL       = 12'h010;
    localparam logic [11:0] GPP_OFF_ORIENTATION       = 12'h014;
    localparam logic [11:0] GPP_OFF_ORIENTATION_SET   = 12'h018;
    localparam logic [11:0] GPP_OFF_ORIENTATION_CLEAR = 12'h01C;
    localparam logic [11:0] GPP_OFF_SENSE_CAPTURE     = 12'h020;
    localparam logic [11:0] GPP_OFF_HIT_SRC           = 12'h024;
    localparam logic [11:0] GPP_OFF_HIT_SRC_SEC       = 12'h028;
    localparam logic [11:0] GPP_OFF_IRQ_STATUS        = 12'h100;
    localparam logic [11:0] GPP_OFF_IRQ_CLEAR         = 12'h104;
    localparam logic [11:0] GPP_OFF_IRQ_ENABLE        = 12'h108;
    localparam logic [11:0] GPP_OFF_CFG_BASE          = 12'h200;
    localparam int unsigned GPP_CFG_IDX_LSB           = 2;
    localparam int unsigned GPP_CFG_IDX_MSB           = 6;
    localparam int unsigned GPP_CFG_REGION_LSB        = 7;

    // ==========================================================================
    // Reset values
    localparam logic [31:0] GPP_RST_ZERO     = 32'h0000_0000;
    localparam logic [31:0] GPP_RST_CFG_WORD = 32'h0000_0002;

    // ==========================================================================
    // Per-line configuration word layout
    localparam int unsigned GPP_CFG_DIR_BIT   = 0;
    localparam int unsigned GPP_CFG_INDIS_BIT = 1;
    localparam int unsigned GPP_CFG_PULL_LSB  = 2;
    localparam int unsigned GPP_CFG_PULL_MSB  = 3;
    localparam int unsigned GPP_CFG_DRV_LSB   = 8;
    localparam int unsigned GPP_CFG_DRV_MSB   = 10;
    localparam int unsigned GPP_CFG_SNS_LSB   = 16;
    localparam int unsigned GPP_CFG_SNS_MSB   = 17;

    localparam logic [1:0] GPP_SENSE_OFF  = 2'h0;
    localparam logic [1:0] GPP_SENSE_HIGH = 2'h2;
    localparam logic [1:0] GPP_SENSE_LOW  = 2'h3;

    localparam int unsigned GPP_HIT_SRC_BIT  = 0;
    localparam int unsigned GPP_IRQ_NSEC_BIT = 0;
    localparam int unsigned GPP_IRQ_SEC_BIT  = 1;
    localparam int unsigned GPP_PROT_NS_BIT  = 1;

    localparam logic [1:0] GPP_RESP_OKAY = 2'h0;

    typedef struct packed {
        logic [1:0] sense;
        logic [2:0] drive;
        logic [1:0] pull;
        logic       in_disc;
    } gpp_cfg_t;

    typedef struct packed {
        logic [11:0] addr;
        logic        non_secure;
    } gpp_req_t;

endpackage : gpp_pkg

// ### design/gpp_port.sv
// GPIO port: drive, direction, input, sense capture and detect logic behind AXI4-Lite
`timescale 1ns/10ps
// What this block does
// - One port reached through secure and non-secure aliases; behaviour follows access type.
// - Drive level register at 0x004, one bit per pin, reset zero.
// - Writing ones to 0x008 sets the matching drive bits high.
// - Writing ones to 0x00C forces the matching drive bits low.
// - Reading either drive alias returns the drive level register.
// - Read-only input level at 0x010 shows pin input levels, reset zero.
// - Direction register at 0x014 with set alias 0x018, clear alias 0x01C.
// - Sense capture at 0x020 records pins that met their configured level.
// - Detect source selectors: 0x024 non-secure pins, 0x028 secure pins.
// - Per-pin configuration words start at 0x200, one word each.
// - Direction set ones make outputs, clear ones make inputs; reads return direction.
// - Capture bits clear only by writing one, never while the pin still meets its sense level.
// - Non-secure access to secure pins: writes ignored, reads zero, no error.
// - Input level follows the pad two clock cycles later.
module gpp_port
    import gpp_pkg::*;
#(
    parameter int unsigned PINS = GPP_PINS
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              clk_en,
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [PINS-1:0]   secure_pins,
    input  wire logic [PINS-1:0]   pad_in,
    output logic [PINS-1:0]        pad_out,
    output logic [PINS-1:0]        pad_oe,
    output logic [PINS-1:0]        pad_in_enable,
    output logic                   detect_nsec,
    output logic                   detect_sec,
    output logic                   irq
);

    // ==========================================================================
    // Helpers
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = GPP_RST_ZERO;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{strb[b]}};
        end
        return m;
    endfunction : strb_mask

    function automatic logic [31:0] cfg_to_word(input gpp_cfg_t c, input logic dir);
        logic [31:0] w;
        w = GPP_RST_ZERO;
        w[GPP_CFG_DIR_BIT] = dir;
        w[GPP_CFG_INDIS_BIT] = c.in_disc;
        w[GPP_CFG_PULL_MSB:GPP_CFG_PULL_LSB] = c.pull;
        w[GPP_CFG_DRV_MSB:GPP_CFG_DRV_LSB] = c.drive;
        w[GPP_CFG_SNS_MSB:GPP_CFG_SNS_LSB] = c.sense;
        return w;
    endfunction : cfg_to_word

    function automatic gpp_cfg_t word_to_cfg(input logic [31:0] w);
        gpp_cfg_t c;
        c.in_disc = w[GPP_CFG_INDIS_BIT];
        c.pull = w[GPP_CFG_PULL_MSB:GPP_CFG_PULL_LSB];
        c.drive = w[GPP_CFG_DRV_MSB:GPP_CFG_DRV_LSB];
        c.sense = w[GPP_CFG_SNS_MSB:GPP_CFG_SNS_LSB];
        return c;
    endfunction : word_to_cfg

    function automatic logic is_cfg(input logic [11:0] a);
        return a[GPP_AW-1:GPP_CFG_REGION_LSB] == GPP_OFF_CFG_BASE[GPP_AW-1:GPP_CFG_REGION_LSB];
    endfunction : is_cfg

    // ==========================================================================
    // State
    localparam gpp_cfg_t CFG_RST = word_to_cfg(GPP_RST_CFG_WORD);

    logic [PINS-1:0] drive_q;
    logic [PINS-1:0] orient_q;
    logic [PINS-1:0] capture_q;
    logic [PINS-1:0] sync1_q;
    logic [PINS-1:0] sync2_q;
    logic [PINS-1:0] in_level;
    logic            hit_src_q;
    logic            hit_src_sec_q;
    gpp_cfg_t        cfg_q [PINS];
    logic [1:0]      irq_stat_q;
    logic [1:0]      irq_en_q;
    logic            det_nsec_q;
    logic            det_sec_q;

    gpp_req_t        aw_q;
    logic            aw_full_q;
    logic [31:0]     wdata_q;
    logic [3:0]      wstrb_q;
    logic            w_full_q;
    logic            bvalid_q;
    logic            arready_q;
    logic            rvalid_q;
    logic [31:0]     rdata_q;

    // ==========================================================================
    // Write channel capture; address and data may come in either order
    logic aw_hs;
    logic w_hs;
    logic wr_go;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs  = s_axi_wvalid && s_axi_wready;
    assign wr_go = aw_full_q && w_full_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= '0;
            aw_full_q <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (clk_en) begin
            if (aw_hs) begin
                aw_q.addr <= s_axi_awaddr;
                aw_q.non_secure <= s_axi_awprot[GPP_PROT_NS_BIT];
            end
            aw_full_q <= (aw_full_q && !wr_go) || aw_hs;
            s_axi_awready <= !((aw_full_q && !wr_go) || aw_hs);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata_q <= GPP_RST_ZERO;
            wstrb_q <= '0;
            w_full_q <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (clk_en) begin
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            w_full_q <= (w_full_q && !wr_go) || w_hs;
            s_axi_wready <= !((w_full_q && !wr_go) || w_hs);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = GPP_RESP_OKAY;

    // ==========================================================================
    // Write decode
    logic [31:0]     pin_mask_w;
    logic [PINS-1:0] wbits;
    logic [PINS-1:0] wmask;
    logic [4:0]      wr_idx;
    logic            wr_cfg_ok;

    assign pin_mask_w = aw_q.non_secure ? 32'(~secure_pins) : ~GPP_RST_ZERO;
    assign wmask  = PINS'(pin_mask_w & strb_mask(wstrb_q));
    assign wbits  = PINS'(wdata_q) & wmask;
    assign wr_idx = aw_q.addr[GPP_CFG_IDX_MSB:GPP_CFG_IDX_LSB];
    assign wr_cfg_ok = wr_go && is_cfg(aw_q.addr) && (32'(wr_idx) < PINS)
                       && !(aw_q.non_secure && secure_pins[wr_idx]);

    logic wr_drv;
    logic wr_drv_set;
    logic wr_drv_clr;
    logic wr_ori;
    logic wr_ori_set;
    logic wr_ori_clr;
    logic wr_cap;
    assign wr_drv     = wr_go && aw_q.addr == GPP_OFF_DRIVE_LEVEL;
    assign wr_drv_set = wr_go && aw_q.addr == GPP_OFF_DRIVE_LEVEL_SET;
    assign wr_drv_clr = wr_go && aw_q.addr == GPP_OFF_DRIVE_LEVEL_CLEAR;
    assign wr_ori     = wr_go && aw_q.addr == GPP_OFF_ORIENTATION;
    assign wr_ori_set = wr_go && aw_q.addr == GPP_OFF_ORIENTATION_SET;
    assign wr_ori_clr = wr_go && aw_q.addr == GPP_OFF_ORIENTATION_CLEAR;
    assign wr_cap     = wr_go && aw_q.addr == GPP_OFF_SENSE_CAPTURE;

    // ==========================================================================
    // Drive level and direction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_q <= PINS'(GPP_RST_ZERO);
        end else if (clk_en) begin
            if (wr_drv) begin
                drive_q <= (drive_q & ~wmask) | wbits;
            end else if (wr_drv_set) begin
                drive_q <= drive_q | wbits;
            end else if (wr_drv_clr) begin
                drive_q <= drive_q & ~wbits;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            orient_q <= PINS'(GPP_RST_ZERO);
        end else if (clk_en) begin
            if (wr_ori) begin
                orient_q <= (orient_q & ~wmask) | wbits;
            end else if (wr_ori_set) begin
                orient_q <= orient_q | wbits;
            end else if (wr_ori_clr) begin
                orient_q <= orient_q & ~wbits;
            end else if (wr_cfg_ok && wstrb_q[0]) begin
                // The config word's direction bit is the same storage as the direction register
                orient_q[wr_idx] <= wdata_q[GPP_CFG_DIR_BIT];
            end
        end
    end

    // ==========================================================================
    // Per-line configuration words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < PINS; i++) begin
                cfg_q[i] <= CFG_RST;
            end
        end else if (clk_en) begin
            if (wr_cfg_ok) begin
                cfg_q[wr_idx] <= word_to_cfg((cfg_to_word(cfg_q[wr_idx], 1'b0) & ~strb_mask(wstrb_q))
                                             | (wdata_q & strb_mask(wstrb_q)));
            end
        end
    end

    // ==========================================================================
    // Input path; a two-stage synchroniser gives the fixed two-cycle latency
    logic [PINS-1:0] connected;
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            connected[i] = !cfg_q[i].in_disc;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= PINS'(GPP_RST_ZERO);
            sync2_q <= PINS'(GPP_RST_ZERO);
        end else if (clk_en) begin
            sync1_q <= pad_in;
            sync2_q <= sync1_q;
        end
    end

    // Read straight off the second flop; one more stage would add a third cycle
    assign in_level = sync2_q & connected;

    // ==========================================================================
    // Sense and detect
    logic [PINS-1:0] pin_hit;
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            pin_hit[i] = connected[i] && ((cfg_q[i].sense == GPP_SENSE_HIGH && sync2_q[i])
                                          || (cfg_q[i].sense == GPP_SENSE_LOW && !sync2_q[i]));
        end
    end

    logic [PINS-1:0] capture_d;
    logic            det_nsec_d;
    logic            det_sec_d;
    // Set wins over clear, so a clear during an active hit leaves the bit standing
    assign capture_d  = (capture_q & ~(wr_cap ? wbits : '0)) | pin_hit;
    assign det_nsec_d = hit_src_q ? |(capture_d & ~secure_pins) : |(pin_hit & ~secure_pins);
    assign det_sec_d  = hit_src_sec_q ? |(capture_d & secure_pins) : |(pin_hit & secure_pins);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_q <= PINS'(GPP_RST_ZERO);
            det_nsec_q <= 1'b0;
            det_sec_q <= 1'b0;
        end else if (clk_en) begin
            capture_q <= capture_d;
            det_nsec_q <= det_nsec_d;
            det_sec_q <= det_sec_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hit_src_q <= 1'b0;
            hit_src_sec_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_go && wstrb_q[0] && aw_q.addr == GPP_OFF_HIT_SRC) begin
                hit_src_q <= wdata_q[GPP_HIT_SRC_BIT];
            end
            if (wr_go && wstrb_q[0] && !aw_q.non_secure && aw_q.addr == GPP_OFF_HIT_SRC_SEC) begin
                hit_src_sec_q <= wdata_q[GPP_HIT_SRC_BIT];
            end
        end
    end

    // ==========================================================================
    // Interrupts on rising detect outputs
    logic [1:0] irq_evt;
    logic [1:0] irq_clr;
    logic [1:0] irq_stat_d;
    assign irq_evt[GPP_IRQ_NSEC_BIT] = det_nsec_d && !det_nsec_q;
    assign irq_evt[GPP_IRQ_SEC_BIT]  = det_sec_d && !det_sec_q;
    assign irq_clr    = (wr_go && wstrb_q[0] && aw_q.addr == GPP_OFF_IRQ_CLEAR) ? wdata_q[1:0] : 2'h0;
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 2'h0;
            irq_en_q <= 2'h0;
            irq <= 1'b0;
        end else if (clk_en) begin
            irq_stat_q <= irq_stat_d;
            if (wr_go && wstrb_q[0] && aw_q.addr == GPP_OFF_IRQ_ENABLE) begin
                irq_en_q <= wdata_q[1:0];
            end
            irq <= |(irq_stat_d & irq_en_q);
        end
    end

    // ==========================================================================
    // Read channel
    logic            ar_hs;
    logic            rd_ns;
    logic [PINS-1:0] rmask;
    logic [4:0]      rd_idx;
    logic [31:0]     rdata_d;
    assign ar_hs  = s_axi_arvalid && arready_q;
    assign rd_ns  = s_axi_arprot[GPP_PROT_NS_BIT];
    assign rmask  = rd_ns ? ~secure_pins : '1;
    assign rd_idx = s_axi_araddr[GPP_CFG_IDX_MSB:GPP_CFG_IDX_LSB];

    always_comb begin
        rdata_d = GPP_RST_ZERO;
        case (s_axi_araddr)
            GPP_OFF_DRIVE_LEVEL,
            GPP_OFF_DRIVE_LEVEL_SET,
            GPP_OFF_DRIVE_LEVEL_CLEAR: rdata_d = 32'(drive_q & rmask);
            GPP_OFF_INPUT_LEVEL:       rdata_d = 32'(in_level & rmask);
            GPP_OFF_ORIENTATION,
            GPP_OFF_ORIENTATION_SET,
            GPP_OFF_ORIENTATION_CLEAR: rdata_d = 32'(orient_q & rmask);
            GPP_OFF_SENSE_CAPTURE:     rdata_d = 32'(capture_q & rmask);
            GPP_OFF_HIT_SRC:           rdata_d[GPP_HIT_SRC_BIT] = hit_src_q;
            GPP_OFF_HIT_SRC_SEC:       rdata_d[GPP_HIT_SRC_BIT] = hit_src_sec_q && !rd_ns;
            GPP_OFF_IRQ_STATUS:        rdata_d[1:0] = irq_stat_q;
            GPP_OFF_IRQ_ENABLE:        rdata_d[1:0] = irq_en_q;
            default: begin
                if (is_cfg(s_axi_araddr) && (32'(rd_idx) < PINS) && !(rd_ns && secure_pins[rd_idx])) begin
                    rdata_d = cfg_to_word(cfg_q[rd_idx], orient_q[rd_idx]);
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= GPP_RST_ZERO;
        end else if (clk_en) begin
            if (ar_hs) begin
                rdata_q <= rdata_d;
                rvalid_q <= 1'b1;
                arready_q <= 1'b0;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end else if (!rvalid_q) begin
                arready_q <= 1'b1;
            end
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = GPP_RESP_OKAY;

    // ==========================================================================
    // Pad side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_out <= PINS'(GPP_RST_ZERO);
            pad_oe <= PINS'(GPP_RST_ZERO);
            pad_in_enable <= PINS'(GPP_RST_ZERO);
        end else if (clk_en) begin
            pad_out <= drive_q;
            pad_oe <= orient_q;
            pad_in_enable <= connected;
        end
    end

    assign detect_nsec = det_nsec_q;
    assign detect_sec  = det_sec_q;

endmodule : gpp_port

// ### testbench/gpp_pad_model.sv
// Pad model: driven pins read back, others follow the outside level
`timescale 1ns/10ps
module gpp_pad_model #(
    parameter int unsigned PINS = 32
) (
    input  wire logic [PINS-1:0] pad_out,
    input  wire logic [PINS-1:0] pad_oe,
    input  wire logic [PINS-1:0] ext_level,
    output logic      [PINS-1:0] pad_in
);
    // No floating pads: an input pin always sees the outside level
    assign pad_in = (pad_out & pad_oe) | (ext_level & ~pad_oe);
endmodule : gpp_pad_model

// ### testbench/gpp_port_props.sv
// Checker for the GPIO port bus answers and pad outputs
`timescale 1ns/10ps
module gpp_port_props
    import gpp_pkg::*;
#(
    parameter int unsigned PINS = 32
) (
    input wire logic            aclk,
    input wire logic            aresetn,
    input wire logic            clk_en,
    input wire logic            s_axi_awvalid,
    input wire logic            s_axi_awready,
    input wire logic            s_axi_wvalid,
    input wire logic            s_axi_wready,
    input wire logic [1:0]      s_axi_bresp,
    input wire logic            s_axi_bvalid,
    input wire logic [11:0]     s_axi_araddr,
    input wire logic [2:0]      s_axi_arprot,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic [31:0]     s_axi_rdata,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire logic [PINS-1:0] secure_pins,
    input wire logic [PINS-1:0] pad_out,
    input wire logic [PINS-1:0] pad_oe,
    input wire logic [PINS-1:0] pad_in_enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========
    // Bus answers
    resp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == GPP_RESP_OKAY)
        else $error("write response not okay");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during read answer");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid && clk_en ##1 clk_en |=> s_axi_bvalid) else $error("write answer late");
    unmapped_zero_a: assert property (s_axi_arvalid && s_axi_arready && clk_en
        && s_axi_araddr >= 12'h02C && s_axi_araddr < 12'h100 |=> s_axi_rdata == 32'h0) else $error("unmapped read");
    ns_mask_a: assert property (s_axi_arvalid && s_axi_arready && clk_en && s_axi_arprot[1]
        && s_axi_araddr < 12'h024 |=> (s_axi_rdata & 32'($past(secure_pins))) == 32'h0)
        else $error("secure bits leaked");
    // ==========
    // Pads move only after a write
    drive_follow_a: assert property ($changed(pad_out) |-> $past(s_axi_bvalid))
        else $error("drive changed without write");
    dir_follow_a: assert property ($changed(pad_oe) |-> $past(s_axi_bvalid))
        else $error("direction changed without write");
    buf_follow_a: assert property ($changed(pad_in_enable) |-> $past(s_axi_bvalid))
        else $error("input buffer changed without write");
endmodule : gpp_port_props

bind gpp_port gpp_port_props #(.PINS(PINS)) u_props (.*);

// ### testbench/tb_gpp_port_register_map.sv
// Testbench for the GPIO port register block
`timescale 1ns/10ps
module tb_gpp_port_register_map;
    logic aclk = 0, aresetn = 0, clk_en = 1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0, b;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0, secure_pins = '0, ext_level = '0, m[2], r;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, detect_nsec, detect_sec;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, pad_in, pad_out, pad_oe, pad_in_enable;
    int num_errors = 0, checked = 0, cyc = 0, j;

    gpp_port DUT (.*);
    gpp_pad_model u_pads (.*);

    always #2.5 aclk = ~aclk;
    // Whole run needs about 430 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            num_errors++;
            final_report();
        end
    end
    // ==========
    // Bus tasks
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ns);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awprot <= {1'b0, ns, 1'b0};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rc(input logic [11:0] a, input logic ns, input logic [31:0] e, input string n);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arprot <= {1'b0, ns, 1'b0};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_arready);
        // Late ready lets the answer stand one cycle unaccepted
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
        end while (!s_axi_rvalid);
        chk(n, s_axi_rdata, e);
        chk("rresp", 32'(s_axi_rresp), '0);
        s_axi_rready <= 1'b0;
    endtask : rc
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // ==========
    // Main sequence
    initial begin
        void'($urandom(32'h5B42));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rc(12'h004, 0, '0, "drive");
        rc(12'h010, 0, '0, "input");
        rc(12'h014, 0, '0, "orient");
        rc(12'h020, 0, '0, "capture");
        rc(12'h028, 0, '0, "hit_sec");
        rc(12'h27C, 0, 32'h2, "config");
        // Even passes drive level, odd passes direction
        for (int k = 0; k < 6; k++) begin
            b = k[0] ? 12'h014 : 12'h004;
            j = k & 1;
            for (int o = 0; o < 3; o++) begin
                r = $urandom;
                wr(b + 12'(4 * o), r, 0);
                m[j] = o == 0 ? r : o == 1 ? m[j] | r : m[j] & ~r;
            end
            for (int o = 0; o < 3; o++)
                rc(b + 12'(4 * o), 0, m[j], "alias");
            chk("pad", k[0] ? pad_oe : pad_out, m[j]);
        end
        wr(12'h014, '0, 0);
        for (int p = 0; p < 32; p++)
            wr(12'h200 + 12'(4 * p), '0, 0);
        ext_level <= $urandom;
        repeat (4) @(posedge aclk);
        rc(12'h010, 0, ext_level, "input");
        // Non-secure view of secure pins
        secure_pins <= $urandom;
        wr(12'h004, '1, 1);
        m[0] = m[0] | ~secure_pins;
        rc(12'h004, 1, m[0] & ~secure_pins, "ns_drive");
        rc(12'h008, 0, m[0], "s_drive");
        rc(12'h010, 1, ext_level & ~secure_pins, "ns_input");
        wr(12'h028, 32'h1, 1);
        rc(12'h028, 0, '0, "ns_hit_sec");
        secure_pins <= '0;
        wr(12'h040, '1, 0);
        rc(12'h040, 0, '0, "unmapped");
        // Sense on pin 3, capture and interrupt
        ext_level <= '0;
        wr(12'h20C, 32'h0002_0000, 0);
        wr(12'h108, 32'h1, 0);
        ext_level <= 32'h8;
        repeat (6) @(posedge aclk);
        chk("detect", {31'h0, detect_nsec}, 32'h1);
        rc(12'h020, 0, 32'h8, "capture");
        chk("irq", {31'h0, irq}, 32'h1);
        wr(12'h020, 32'h8, 0);
        rc(12'h020, 0, 32'h8, "held");
        ext_level <= '0;
        wr(12'h108, '0, 0);
        @(posedge aclk);
        chk("masked", {31'h0, irq}, '0);
        wr(12'h020, 32'h8, 0);
        rc(12'h020, 0, '0, "cleared");
        rc(12'h100, 0, 32'h1, "status");
        wr(12'h104, 32'h1, 0);
        rc(12'h100, 0, '0, "status_clr");
        // Captured mode keeps detect up after the pin drops
        wr(12'h024, 32'h1, 0);
        ext_level <= 32'h8;
        repeat (4) @(posedge aclk);
        ext_level <= '0;
        repeat (4) @(posedge aclk);
        chk("held_detect", {31'h0, detect_nsec}, 32'h1);
        wr(12'h020, 32'h8, 0);
        repeat (2) @(posedge aclk);
        chk("detect_off", {31'h0, detect_nsec}, '0);
        secure_pins <= 32'h8;
        ext_level <= 32'h8;
        repeat (5) @(posedge aclk);
        chk("detect_sec", {31'h0, detect_sec}, 32'h1);
        chk("detect_ns", {31'h0, detect_nsec}, '0);
        final_report();
    end
endmodule : tb_gpp_port_register_map
